// >>> pkg/npic_pkg.sv
// constants shared by the nested priority interrupt controller
package npic_pkg;
  // =====================================================================
  // register port map
  // =====================================================================
  localparam logic [7:0] PRIO0_ADDR = 8'h24; // first priority register
  localparam logic [7:0] PRIO3_ADDR = 8'h27; // last priority register
  localparam logic [7:0] CC_ADDR = 8'h30; // condition codes window
  localparam logic [7:0] PRIO_RESET = 8'hff; // every field at level 3
  localparam logic [7:0] PRIO3_RO_ONES = 8'hf0; // fixed upper nibble
  localparam logic [7:0] CC_RESET = 8'hea; // level 3, bit 1 set, other flags clear
  localparam logic [7:0] CC_FIXED_ONES = 8'hc0; // bits 7:6 read one
  // =====================================================================
  // condition code layout
  // =====================================================================
  localparam int CC_PRIO_HI = 5; // priority_bit_high
  localparam int CC_PRIO_LO = 3; // priority_bit_low
  // =====================================================================
  // priority level codes {high, low}
  // =====================================================================
  localparam logic [1:0] LVL0 = 2'h2; // main, lowest
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3; // maskable sources blocked
  localparam logic [2:0] RANK_TOP = 3'h4; // above any field level
  // =====================================================================
  // vector table
  // =====================================================================
  localparam int NUM_VEC = 14; // vectors with a priority field
  localparam int NUM_PRIO_REGS = 4; // priority registers
  localparam int FIELDS_PER_REG = 4; // two-bit fields per register
  localparam int FIELD_W = 2; // bits per field
  localparam int TLI_VEC = 0; // top_level_interrupt
  localparam int CLK_VEC = 1; // time base and clock security share
  localparam int UNUSED_VEC = 6; // no source behind it
  localparam int SPI_VEC = 7; // wakes only in slave mode
  localparam int PWM_VEC = 13; // wakes only on external clock
  localparam logic [13:0] WAKE_MASK = 14'h003f; // always waking
  localparam logic [15:0] VEC_RESET = 16'hfffe; // reset vector
  localparam logic [15:0] VEC_TRAP = 16'hfffc; // software trap vector
  localparam logic [15:0] VEC_TLI = 16'hfffa; // vector 0, then down
  localparam int PUSH_BYTES = 5; // PC high/low, X, A, CC
  // controller sequence
  typedef enum logic [1:0] {
    NPIC_BOOT,
    NPIC_RUN,
    NPIC_STACK,
    NPIC_FETCH
  } npic_state_t;
endpackage

// >>> src/npic_ctrl.sv
// nested priority interrupt controller beside the core sequencer
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module npic_ctrl
  import npic_pkg::*;
(
  input wire logic i_core_clk, // core clock, 25 MHz
  input wire logic i_reset, // synchronous, active high
  input wire logic [7:0] i_reg_addr, // register address
  input wire logic [7:0] i_reg_wdata, // register write data
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  output logic [7:0] o_reg_rdata, // read data, cycle after strobe
  input wire logic [13:0] i_irq_pending, // latched source requests
  input wire logic [13:0] i_irq_enable, // source enables
  input wire logic i_clk_timebase_irq, // clock_controller_timebase
  input wire logic i_clk_security_irq, // clock_security_system
  input wire logic i_instr_done, // current instruction finished
  input wire logic i_trap_instr, // software trap executed
  input wire logic i_enable_instr, // enable_interrupts_instr
  input wire logic i_disable_instr, // disable_interrupts_instr
  input wire logic i_halt_instr, // halt entry
  input wire logic i_wfi_instr, // wait_for_interrupt_instr
  input wire logic i_pop_condition_codes_instr, // pop_condition_codes
  input wire logic i_return_from_interrupt_instr_instr, // return_from_interrupt_instr
  input wire logic [7:0] i_stacked_cc, // value popped from stack
  input wire logic i_halted, // core in halt or active halt
  input wire logic i_spi_slave, // serial port in slave mode
  input wire logic i_pwm_ext_clk, // pwm timer on external clock
  output logic [7:0] o_cc, // cpu_condition_codes
  output logic o_push_strobe, // one stack byte per cycle
  output logic o_vector_valid, // fetch vector this cycle
  output logic [15:0] o_vector_addr, // vector address to fetch
  output logic o_wake, // wake core from halt
  output logic o_jump_masked, // jump_if_masked condition
  output logic o_jump_not_masked // jump_if_not_masked condition
);
  // =====================================================================
  // state
  // =====================================================================
  npic_state_t state_reg; // controller sequence
  logic [7:0] cc_reg; // condition codes
  logic [7:0] prio_reg [NUM_PRIO_REGS]; // vector_priority_regs
  logic trap_pend_reg; // trap waiting for its boundary
  logic [2:0] push_cnt_reg; // stacked bytes so far
  logic [15:0] vec_addr_reg; // chosen vector address
  logic [1:0] new_prio_reg; // level loaded at fetch
  logic [1:0] cur_level; // current {high, low}
  logic [1:0] cur_rank; // current level as rank
  logic [13:0] wake_ok; // sources able to wake
  logic [13:0] elig; // serviceable this boundary
  logic [1:0] field_w [NUM_VEC]; // per-vector field
  logic [2:0] rank_w [NUM_VEC]; // per-vector rank
  logic found; // any eligible source
  logic [3:0] best_vec; // winning vector
  logic [2:0] best_rank; // winning rank
  logic trap_req; // trap to service
  logic take; // start servicing now

  // level code to ordered rank: 10->0, 01->1, 00->2, 11->3
  function automatic logic [1:0] prio_rank(input logic [1:0] c);
    prio_rank = {~(c[1] ^ c[0]), c[0]};
  endfunction

  // merge a written byte, keeping any field written as level 0
  function automatic logic [7:0] prio_merge(input logic [7:0] old,
                                            input logic [7:0] wr);
    logic [7:0] res;
    res = wr;
    for (int f = 0; f < FIELDS_PER_REG; f++)
    begin
      if (wr[f*FIELD_W +: FIELD_W] == LVL0)
      begin
        res[f*FIELD_W +: FIELD_W] = old[f*FIELD_W +: FIELD_W];
      end
    end
    prio_merge = res;
  endfunction

  assign cur_level = {cc_reg[CC_PRIO_HI], cc_reg[CC_PRIO_LO]};
  assign cur_rank = prio_rank(cur_level);
  assign o_cc = cc_reg | CC_FIXED_ONES;
  assign o_jump_masked = (cur_level == LVL3);
  assign o_jump_not_masked = (cur_level != LVL3);
  assign o_push_strobe = (state_reg == NPIC_STACK);
  assign o_vector_valid = (state_reg == NPIC_FETCH);
  assign o_vector_addr = vec_addr_reg;
  assign trap_req = trap_pend_reg | i_trap_instr;

  // =====================================================================
  // wake capability
  // =====================================================================
  // conditional sources follow their peripheral mode
  always_comb
  begin
    wake_ok = WAKE_MASK;
    wake_ok[SPI_VEC] = i_spi_slave;
    wake_ok[PWM_VEC] = i_pwm_ext_clk;
  end

  // halt exit on any enabled waking source above the current level
  assign o_wake = |(elig & wake_ok);

  // =====================================================================
  // per-vector field and eligibility
  // =====================================================================
  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv++)
    begin : g_vec
      logic pend; // request including shared sources
      // field pairs taken in order across the registers
      assign field_w[gv] = prio_reg[gv / FIELDS_PER_REG]
        [(gv % FIELDS_PER_REG) * FIELD_W +: FIELD_W];
      // top level ranks above all, its field unused
      assign rank_w[gv] = (gv == TLI_VEC) ? RANK_TOP :
        {1'b0, prio_rank(field_w[gv])};
      // vector 1 is the or of its own request and both clock sources
      if (gv == CLK_VEC)
      begin : g_shared
        assign pend = i_irq_pending[gv] | i_clk_timebase_irq |
          i_clk_security_irq;
      end
      else
      begin : g_plain
        assign pend = i_irq_pending[gv];
      end
      // enabled, above current level, and waking if halted
      assign elig[gv] = pend & i_irq_enable[gv] &
        (gv != UNUSED_VEC) & (~i_halted | wake_ok[gv]) &
        (rank_w[gv] > {1'b0, cur_rank});
    end
  endgenerate

  // =====================================================================
  // arbitration
  // =====================================================================
  // scan low priority first so ties fall to the lower number
  always_comb
  begin
    found = 1'b0;
    best_vec = 4'h0;
    best_rank = 3'h0;
    for (int v = NUM_VEC - 1; v >= 0; v--)
    begin
      if (elig[v] && (!found || rank_w[v] >= best_rank))
      begin
        found = 1'b1;
        best_vec = 4'(v);
        best_rank = rank_w[v];
      end
    end
  end

  // service only at an instruction boundary
  assign take = (state_reg == NPIC_RUN) && i_instr_done &&
    (trap_req || found);

  // =====================================================================
  // sequence
  // =====================================================================
  // boot fetch, stack bytes, then fetch vector
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state_reg <= NPIC_BOOT;
      push_cnt_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        NPIC_BOOT:
        begin
          // reset vectors with no stacking
          state_reg <= NPIC_FETCH;
        end
        NPIC_RUN:
        begin
          if (take)
          begin
            state_reg <= NPIC_STACK;
            push_cnt_reg <= 3'h0;
          end
        end
        NPIC_STACK:
        begin
          // PC, X, A and CC go out one per cycle
          if (push_cnt_reg == 3'(PUSH_BYTES - 1))
          begin
            state_reg <= NPIC_FETCH;
          end
          push_cnt_reg <= push_cnt_reg + 3'h1;
        end
        default:
        begin
          state_reg <= NPIC_RUN;
        end
      endcase
    end
  end

  // vector address and entry level chosen at the boundary
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      vec_addr_reg <= VEC_RESET;
      new_prio_reg <= LVL3;
    end
    else if (take)
    begin
      if (trap_req)
      begin
        // trap has no field and passes level 3
        vec_addr_reg <= VEC_TRAP;
        new_prio_reg <= LVL3;
      end
      else
      begin
        // descending two bytes per vector
        vec_addr_reg <= VEC_TLI - 16'({best_vec, 1'b0});
        // re-entry follows the field as it stands now
        if (best_vec == 4'(TLI_VEC))
        begin
          new_prio_reg <= LVL3;
        end
        else
        begin
          new_prio_reg <= field_w[best_vec];
        end
      end
    end
  end

  // trap held until taken; a pulse consumed by this take is not kept,
  // but a new trap arriving while an older one is taken stays pending
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      trap_pend_reg <= 1'b0;
    end
    else if (take)
    begin
      trap_pend_reg <= trap_pend_reg & i_trap_instr;
    end
    else if (i_trap_instr)
    begin
      trap_pend_reg <= 1'b1;
    end
  end

  // =====================================================================
  // condition codes
  // =====================================================================
  // entry load, then stack restore, then instruction loads
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      cc_reg <= CC_RESET;
    end
    else if (state_reg == NPIC_FETCH)
    begin
      cc_reg[CC_PRIO_HI] <= new_prio_reg[1];
      cc_reg[CC_PRIO_LO] <= new_prio_reg[0];
    end
    else if (i_pop_condition_codes_instr || i_return_from_interrupt_instr_instr)
    begin
      cc_reg <= i_stacked_cc | CC_FIXED_ONES;
    end
    else if (i_disable_instr)
    begin
      cc_reg[CC_PRIO_HI] <= LVL3[1];
      cc_reg[CC_PRIO_LO] <= LVL3[0];
    end
    else if (i_enable_instr || i_halt_instr || i_wfi_instr)
    begin
      cc_reg[CC_PRIO_HI] <= LVL0[1];
      cc_reg[CC_PRIO_LO] <= LVL0[0];
    end
    else if (i_reg_wr && i_reg_addr == CC_ADDR)
    begin
      cc_reg <= i_reg_wdata | CC_FIXED_ONES;
    end
  end

  // =====================================================================
  // priority registers
  // =====================================================================
  genvar gr;
  generate
    for (gr = 0; gr < NUM_PRIO_REGS; gr++)
    begin : g_prio
      // fixed nibble only on the last register
      localparam logic [7:0] RO = (gr == NUM_PRIO_REGS - 1) ?
        PRIO3_RO_ONES : 8'h00;
      always_ff @(posedge i_core_clk)
      begin
        if (i_reset)
        begin
          prio_reg[gr] <= PRIO_RESET;
        end
        else if (i_reg_wr && i_reg_addr == PRIO0_ADDR + 8'(gr))
        begin
          prio_reg[gr] <= prio_merge(prio_reg[gr], i_reg_wdata) |
            RO;
        end
      end
    end
  endgenerate

  // =====================================================================
  // register read port
  // =====================================================================
  // data stand the cycle after the strobe; unmapped read zero
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= 8'h00;
    end
    else if (i_reg_rd)
    begin
      if (i_reg_addr == CC_ADDR)
      begin
        o_reg_rdata <= cc_reg | CC_FIXED_ONES;
      end
      else if (i_reg_addr >= PRIO0_ADDR && i_reg_addr <= PRIO3_ADDR)
      begin
        o_reg_rdata <= prio_reg[i_reg_addr[1:0]];
      end
      else
      begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // maskable entry takes the chosen field
  entry_level_a: assert property (
    (state_reg == NPIC_FETCH) |=> (cur_level == $past(new_prio_reg)))
    else $error("entry level not loaded");

  // jump conditions follow level coding
  jump_cond_a: assert property (
    o_jump_masked == (o_cc[CC_PRIO_HI] && o_cc[CC_PRIO_LO]) &&
    (o_jump_masked != o_jump_not_masked))
    else $error("jump condition mismatch");

  // trap vector enters at level 3
  trap_level_a: assert property (
    (o_vector_valid && o_vector_addr == VEC_TRAP) |=>
    (cur_level == LVL3))
    else $error("trap not at level 3");

  // level 0 field write is dropped
  level0_keep_a: assert property (
    (i_reg_wr && i_reg_addr == PRIO0_ADDR &&
     i_reg_wdata[1:0] == LVL0) |=>
    (prio_reg[0][1:0] == $past(prio_reg[0][1:0])))
    else $error("level 0 write stored");

  // fixed nibble reads ones
  prio3_ro_a: assert property (
    (i_reg_rd && i_reg_addr == PRIO3_ADDR) |=>
    (o_reg_rdata[7:4] == PRIO3_RO_ONES[7:4]))
    else $error("fixed nibble not ones");

  // stacking lasts the byte count then vectors
  stack_len_a: assert property (
    $rose(o_push_strobe) |-> o_push_strobe [*5] ##1 o_vector_valid)
    else $error("stack length wrong");

  // pop restores the stacked level
  pop_restore_a: assert property (
    (i_pop_condition_codes_instr && state_reg != NPIC_FETCH) |=>
    (o_cc[CC_PRIO_HI] == $past(i_stacked_cc[CC_PRIO_HI]) &&
     o_cc[CC_PRIO_LO] == $past(i_stacked_cc[CC_PRIO_LO])))
    else $error("pop did not restore level");

  // enable instruction lowers to level 0
  enable_load_a: assert property (
    (i_enable_instr && state_reg != NPIC_FETCH && !i_pop_condition_codes_instr &&
     !i_return_from_interrupt_instr_instr && !i_disable_instr) |=> (cur_level == LVL0))
    else $error("enable did not load level 0");

  // reset fetches its vector soon after release
  reset_vec_a: assert property (
    ($past(i_reset) && !i_reset) |-> ##[0:2]
    (o_vector_valid && o_vector_addr == VEC_RESET))
    else $error("reset vector not fetched");

  // fixed condition code bits
  cc_fixed_a: assert property (
    o_cc[7:6] == CC_FIXED_ONES[7:6])
    else $error("cc upper bits not ones");
endmodule
`default_nettype wire

// >>> tb/npic_core_model.sv
// core-side model: instruction boundaries and stack byte count
`timescale 1ns/1ps
`default_nettype none
module npic_core_model
(
  input wire logic i_core_clk, // core clock
  input wire logic i_reset, // synchronous, active high
  input wire logic i_hold, // stretch the current instruction
  input wire logic i_push_strobe, // stack byte written this cycle
  input wire logic i_vector_valid, // vector fetched this cycle
  output logic o_instr_done, // instruction boundary
  output logic [3:0] o_push_count // bytes pushed since last fetch
);
  // =====================================================================
  // instruction sequencing
  // =====================================================================
  // boundary only between instructions, never while stacking or fetching
  assign o_instr_done = !i_hold && !i_push_strobe && !i_vector_valid;
  // count stack bytes pushed since the last vector fetch
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || i_vector_valid)
      o_push_count <= 4'h0;
    else if (i_push_strobe)
      o_push_count <= o_push_count + 4'h1;
  end
endmodule
`default_nettype wire

// >>> tb/npic_ctrl_tb.sv
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module npic_ctrl_tb;
  import npic_pkg::*;
  // =====================================================================
  // stimulus and observation
  // =====================================================================
  logic clk = 1'b0; // core clock, 40 ns
  logic rst = 1'b1; // synchronous reset
  logic [7:0] addr = 8'h00; // register address
  logic [7:0] wdata = 8'h00; // register write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic [13:0] pend = 14'h0000; // source requests
  logic [13:0] en = 14'h0000; // source enables
  logic [1:0] clk_irq = 2'h0; // time base, clock security
  logic [6:0] ins = 7'h00; // enable disable halt wfi pop return_from_interrupt_instr trap
  logic [7:0] scc = 8'h00; // stacked condition codes
  logic halted = 1'b0; // core halted
  logic spi_slave = 1'b0; // serial port slave mode
  logic hold = 1'b0; // core mid-instruction
  logic pwm_ext = 1'b0; // pwm timer on external clock
  logic done, push, vvalid, wake, jm, jnm;
  logic [7:0] rdata, cc;
  logic [15:0] vaddr;
  logic [3:0] npush;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  npic_ctrl dut_u (.i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_irq_pending(pend), .i_irq_enable(en), .i_clk_timebase_irq(clk_irq[0]),
    .i_clk_security_irq(clk_irq[1]), .i_instr_done(done),
    .i_trap_instr(ins[6]), .i_enable_instr(ins[0]), .i_disable_instr(ins[1]),
    .i_halt_instr(ins[2]), .i_wfi_instr(ins[3]), .i_pop_condition_codes_instr(ins[4]),
    .i_return_from_interrupt_instr_instr(ins[5]), .i_stacked_cc(scc), .i_halted(halted),
    .i_spi_slave(spi_slave), .i_pwm_ext_clk(pwm_ext), .o_cc(cc),
    .o_push_strobe(push), .o_vector_valid(vvalid), .o_vector_addr(vaddr),
    .o_wake(wake), .o_jump_masked(jm), .o_jump_not_masked(jnm));
  npic_core_model model_u (.i_core_clk(clk), .i_reset(rst), .i_hold(hold),
    .i_push_strobe(push), .i_vector_valid(vvalid), .o_instr_done(done),
    .o_push_count(npush));
  // =====================================================================
  // shared tasks
  // =====================================================================
  // compare and count
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // counts, verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle read, data compared in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", {8'h00, e}, {8'h00, rdata});
  endtask
  // one-cycle instruction pulse with its stacked value
  task automatic pulse(input int k, input logic [7:0] s);
    @(posedge clk);
    scc <= s;
    ins[k] <= 1'b1;
    @(posedge clk);
    ins[k] <= 1'b0;
    #1;
  endtask
  // raise requests on a rising edge
  task automatic raise(input logic [13:0] e, input logic [13:0] p);
    @(posedge clk);
    en <= e;
    pend <= p;
  endtask
  // current level pair from the condition codes
  function automatic logic [15:0] lvl();
    return {14'h0000, cc[CC_PRIO_HI], cc[CC_PRIO_LO]};
  endfunction
  // wait for a fetch, judge address, stacking and the new level
  task automatic serve(input logic [15:0] va, input logic [1:0] lv,
    input logic [3:0] np, input logic keep);
    int i;
    @(negedge clk);
    for (i = 0; i < 60 && vvalid !== 1'b1; i++)
      @(negedge clk);
    chk("vector valid", 16'h0001, {15'h0000, vvalid});
    chk("vector addr", va, vaddr);
    chk("push count", {12'h000, np}, {12'h000, npush});
    if (!keep)
      pend <= 14'h0000;
    clk_irq <= 2'h0;
    @(negedge clk);
    chk("entry level", {14'h0000, lv}, lvl());
  endtask
  // no fetch for n cycles
  task automatic quiet(input int n);
    int seen = 0;
    repeat (n)
    begin
      @(negedge clk);
      if (vvalid === 1'b1)
        seen++;
    end
    chk("no service", 16'h0000, 16'(seen));
  endtask
  // =====================================================================
  // scenarios
  // =====================================================================
  // reset values, unmapped read, field writes and fixed bits
  task automatic t_regs();
    int i;
    for (i = 0; i < 4; i++)
      rd_chk(PRIO0_ADDR + 8'(i), 8'hff);
    rd_chk(CC_ADDR, 8'hea);
    rd_chk(8'h50, 8'h00);
    reg_wr(PRIO0_ADDR, 8'hcf);
    reg_wr(PRIO0_ADDR, 8'h64);
    rd_chk(PRIO0_ADDR, 8'h44);
    reg_wr(PRIO3_ADDR, 8'h00);
    rd_chk(PRIO3_ADDR, 8'hf0);
    reg_wr(PRIO3_ADDR, 8'hff);
    reg_wr(CC_ADDR, 8'h00);
    rd_chk(CC_ADDR, 8'hc0);
  endtask
  // level instructions, jump conditions, pop and return
  task automatic t_instr();
    logic [1:0] lv [4] = '{LVL0, LVL3, LVL0, LVL0};
    int k;
    for (k = 0; k < 4; k++)
    begin
      pulse(k, 8'h00);
      chk("level", {14'h0000, lv[k]}, lvl());
      chk("jump masked", {15'h0000, lv[k] == LVL3}, {15'h0000, jm});
      chk("jump not masked", {15'h0000, lv[k] != LVL3}, {15'h0000, jnm});
    end
    repeat (10) @(posedge clk);
    chk("level kept", {14'h0000, LVL0}, lvl());
    pulse(4, 8'h15);
    chk("popped cc", 16'h00d5, {8'h00, cc});
    pulse(5, 8'h2a);
    chk("returned cc", 16'h00ea, {8'h00, cc});
  endtask
  // boundary wait, enable gating, entry level and re-entry
  task automatic t_service();
    pulse(0, 8'h00);
    reg_wr(PRIO0_ADDR, 8'hdf);
    raise(14'h0000, 14'h0004);
    quiet(10);
    @(posedge clk);
    hold <= 1'b1;
    raise(14'h0004, 14'h0004);
    quiet(10);
    @(posedge clk);
    hold <= 1'b0;
    serve(VEC_TLI - 16'h0004, LVL1, 4'h5, 1'b1);
    quiet(5);
    reg_wr(PRIO0_ADDR, 8'hcf);
    serve(VEC_TLI - 16'h0004, LVL2, 4'h5, 1'b0);
    pulse(5, 8'he2);
    chk("returned level", {14'h0000, LVL0}, lvl());
  endtask
  // hardware order on a level tie first, then software level
  task automatic t_order();
    reg_wr(PRIO0_ADDR, 8'h7f);
    reg_wr(PRIO2_ADDR_OF(), 8'hfd);
    raise(14'h0108, 14'h0108);
    serve(VEC_TLI - 16'h0006, LVL1, 4'h5, 1'b0);
    pulse(0, 8'h00);
    reg_wr(PRIO2_ADDR_OF(), 8'hfc);
    raise(14'h0108, 14'h0108);
    serve(VEC_TLI - 16'h0010, LVL2, 4'h5, 1'b0);
    pulse(0, 8'h00);
  endtask
  // third priority register address
  function automatic logic [7:0] PRIO2_ADDR_OF();
    return PRIO0_ADDR + 8'h02;
  endfunction
  // level 3 blocks sources, trap and top level still enter
  task automatic t_mask();
    pulse(1, 8'h00);
    raise(14'h0004, 14'h0004);
    quiet(10);
    pulse(6, 8'h00);
    serve(VEC_TRAP, LVL3, 4'h5, 1'b0);
    reg_wr(PRIO0_ADDR, 8'hfc);
    raise(14'h0001, 14'h0001);
    serve(VEC_TLI, LVL3, 4'h5, 1'b0);
    pulse(0, 8'h00);
  endtask
  // both clock sources share one vector
  task automatic t_clock();
    int j;
    for (j = 0; j < 2; j++)
    begin
      raise(14'h0002, 14'h0000);
      clk_irq[j] <= 1'b1;
      serve(VEC_TLI - 16'h0002, LVL3, 4'h5, 1'b0);
      pulse(0, 8'h00);
    end
  endtask
  // halt lets only waking sources through
  task automatic t_wake();
    halted <= 1'b1;
    raise(14'h3fff, 14'h0100);
    #1;
    chk("wake timer", 16'h0000, {15'h0000, wake});
    quiet(10);
    raise(14'h3fff, 14'h0080);
    #1;
    chk("wake master", 16'h0000, {15'h0000, wake});
    spi_slave <= 1'b1;
    #1;
    chk("wake slave", 16'h0001, {15'h0000, wake});
    serve(VEC_TLI - 16'h000e, LVL3, 4'h5, 1'b0);
    pulse(0, 8'h00);
    raise(14'h3fff, 14'h2000);
    #1;
    chk("wake pwm internal", 16'h0000, {15'h0000, wake});
    pwm_ext <= 1'b1;
    #1;
    chk("wake pwm external", 16'h0001, {15'h0000, wake});
    serve(VEC_TLI - 16'h001a, LVL3, 4'h5, 1'b0);
    pwm_ext <= 1'b0;
    halted <= 1'b0;
    spi_slave <= 1'b0;
    pulse(0, 8'h00);
  endtask
  // =====================================================================
  // sequence and watchdog
  // =====================================================================
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    serve(VEC_RESET, LVL3, 4'h0, 1'b1);
    t_regs();
    t_instr();
    t_service();
    t_order();
    t_mask();
    t_clock();
    t_wake();
    close_out();
  end
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
endmodule
`default_nettype wire
